// file: logic/pwr_mgr_defs.svh
// Constants for the sleep and stop power manager
`ifndef PWR_MGR_DEFS_SVH
`define PWR_MGR_DEFS_SVH
`define PM_NUM_PERIPH 8
`define PM_NUM_EXT_IRQ 4
`define PM_PERIPH_EN_RESET 8'hff
`endif

// file: logic/pwr_mgr_pkg.sv
// Types for the sleep and stop power manager
package pwr_mgr_pkg;
  typedef enum logic [1:0] {
    st_run,
    st_drain,
    st_sleep,
    st_stop
  } pm_state_t;

  typedef struct packed {
    logic sleep_req;
    logic stop_req;
    logic insn_done;
  } core_req_t;

  typedef struct packed {
    logic core_clk_en;
    logic ext_clk_en;
    logic resume;
    logic take_irq;
  } core_ctl_t;
endpackage

// file: logic/sleep_stop_power_manager.sv
// Sleep and stop clock control for core and peripherals
`timescale 1ns/1ps
`include "pwr_mgr_defs.svh"

module sleep_stop_power_manager #(
  parameter int NUM_PERIPH = `PM_NUM_PERIPH,
  parameter int NUM_EXT_IRQ = `PM_NUM_EXT_IRQ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input pwr_mgr_pkg::core_req_t core_req,
  input wire logic [NUM_PERIPH-1:0] periph_en,
  input wire logic int_irq,
  input wire logic [NUM_EXT_IRQ-1:0] ext_irq,
  input wire logic irq_prio_ok,
  output pwr_mgr_pkg::core_ctl_t core_ctl,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic sleeping,
  output logic stopped
);

  typedef struct packed {
    pwr_mgr_pkg::pm_state_t state;
    logic go_stop;
    logic [NUM_EXT_IRQ-1:0] ext_s1;
    logic [NUM_EXT_IRQ-1:0] ext_s2;
    pwr_mgr_pkg::core_ctl_t ctl;
    logic [NUM_PERIPH-1:0] pclk;
    logic sleeping;
    logic stopped;
  } pm_regs_t;

  pm_regs_t st_reg;
  pm_regs_t st_next;
  logic wake_any;
  logic wake_ext;

  // Off-chip lines pass two flops before use
  assign wake_ext = |st_reg.ext_s2;
  assign wake_any = wake_ext | int_irq;

  // Stop is the one state that forces every peripheral gate shut
  function automatic logic in_stop(input pwr_mgr_pkg::pm_state_t s);
    return s == pwr_mgr_pkg::st_stop;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.ext_s1 = ext_irq;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ctl.resume = 1'h0;
    st_next.ctl.take_irq = 1'h0;
    case (st_reg.state)
      pwr_mgr_pkg::st_run: begin
        if (core_req.stop_req) begin
          st_next.state = pwr_mgr_pkg::st_drain;
          st_next.go_stop = 1'h1;
        end else if (core_req.sleep_req) begin
          st_next.state = pwr_mgr_pkg::st_drain;
          st_next.go_stop = 1'h0;
        end
      end
      pwr_mgr_pkg::st_drain: begin
        // Clock stays on until the instruction retires
        if (core_req.insn_done) begin
          st_next.ctl.core_clk_en = 1'h0;
          if (st_reg.go_stop) begin
            st_next.state = pwr_mgr_pkg::st_stop;
            st_next.ctl.ext_clk_en = 1'h0;
            st_next.pclk = '0;
            st_next.stopped = 1'h1;
          end else begin
            st_next.state = pwr_mgr_pkg::st_sleep;
            st_next.sleeping = 1'h1;
          end
        end
      end
      pwr_mgr_pkg::st_sleep: begin
        if (wake_any) begin
          st_next.state = pwr_mgr_pkg::st_run;
          st_next.ctl.core_clk_en = 1'h1;
          st_next.ctl.resume = 1'h1;
          st_next.ctl.take_irq = irq_prio_ok;
          st_next.sleeping = 1'h0;
        end
      end
      pwr_mgr_pkg::st_stop: begin
        // Only external lines wake stop: internal sources are unclocked
        if (wake_ext) begin
          st_next.state = pwr_mgr_pkg::st_run;
          st_next.ctl.ext_clk_en = 1'h1;
          st_next.ctl.core_clk_en = 1'h1;
          st_next.ctl.resume = 1'h1;
          st_next.ctl.take_irq = irq_prio_ok;
          st_next.stopped = 1'h0;
        end
      end
      default: st_next.state = pwr_mgr_pkg::st_run;
    endcase
    if (!in_stop(st_next.state)) begin
      st_next.pclk = periph_en;
    end
  end

  // Enables only from flops; cell latches them while mclk is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.state <= pwr_mgr_pkg::st_run;
      st_reg.go_stop <= 1'h0;
      st_reg.ext_s1 <= '0;
      st_reg.ext_s2 <= '0;
      st_reg.ctl.core_clk_en <= 1'h1;
      st_reg.ctl.ext_clk_en <= 1'h1;
      st_reg.ctl.resume <= 1'h0;
      st_reg.ctl.take_irq <= 1'h0;
      st_reg.pclk <= NUM_PERIPH'(`PM_PERIPH_EN_RESET);
      st_reg.sleeping <= 1'h0;
      st_reg.stopped <= 1'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign core_ctl = st_reg.ctl;
  assign periph_clk_en = st_reg.pclk;
  assign sleeping = st_reg.sleeping;
  assign stopped = st_reg.stopped;

  chk_sleep_gates_core: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_drain && !st_reg.go_stop && core_req.insn_done
    |=> !core_ctl.core_clk_en && sleeping && core_ctl.ext_clk_en)
    else $error("sleep entry did not gate core clock");
  chk_drain_keeps_clk: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_drain && !core_req.insn_done |=> core_ctl.core_clk_en)
    else $error("core clock cut before instruction done");
  chk_sleep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_sleep && (int_irq || wake_ext)
    |=> core_ctl.core_clk_en && core_ctl.resume && !sleeping)
    else $error("sleep wake missing");
  chk_wake_irq_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.resume |-> core_ctl.take_irq == $past(irq_prio_ok))
    else $error("interrupt take does not follow priority");
  chk_stop_all_off: assert property (@(posedge mclk) disable iff (!rst_n)
    stopped |-> !core_ctl.ext_clk_en && !core_ctl.core_clk_en && periph_clk_en == '0)
    else $error("clock running in stop");
  chk_stop_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    stopped && wake_ext |=> core_ctl.ext_clk_en && !stopped)
    else $error("stop wake missing");
  chk_stop_int_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    stopped && !wake_ext |=> stopped && !core_ctl.resume)
    else $error("stop left without external interrupt");
  chk_periph_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    !stopped && !in_stop(st_reg.state) ##1 !in_stop(st_reg.state)
    |-> periph_clk_en == $past(periph_en))
    else $error("peripheral enable not applied");

  // Request, entry and sleep-hold checks
  chk_request_taken: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_run && (core_req.sleep_req || core_req.stop_req)
    |=> st_reg.state == pwr_mgr_pkg::st_drain && core_ctl.core_clk_en)
    else $error("request not taken into drain");
  chk_stop_wins_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_run && core_req.stop_req
    |=> st_reg.go_stop)
    else $error("stop request not recorded");
  chk_stop_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_drain && st_reg.go_stop && core_req.insn_done
    |=> stopped && !sleeping && !core_ctl.core_clk_en && !core_ctl.ext_clk_en)
    else $error("stop entry did not halt clocks");
  chk_drain_no_resume: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.state == pwr_mgr_pkg::st_drain |=> !core_ctl.resume && !core_ctl.take_irq)
    else $error("resume pulse while draining");
  chk_sleep_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    sleeping && !int_irq && !wake_ext |=> sleeping && !core_ctl.core_clk_en)
    else $error("sleep left without interrupt");
  chk_sleep_keeps_rest: assert property (@(posedge mclk) disable iff (!rst_n)
    sleeping |-> core_ctl.ext_clk_en && periph_clk_en == $past(periph_en))
    else $error("sleep disturbed external or peripheral clocks");

  // Wake checks
  chk_resume_single: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.resume |=> !core_ctl.resume)
    else $error("resume pulse longer than one cycle");
  chk_resume_source: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.resume |-> st_reg.state == pwr_mgr_pkg::st_run && core_ctl.core_clk_en
    && ($past(st_reg.state) == pwr_mgr_pkg::st_sleep
    || $past(st_reg.state) == pwr_mgr_pkg::st_stop))
    else $error("resume pulse without a wake");
  chk_take_with_resume: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.take_irq |-> core_ctl.resume)
    else $error("interrupt taken without wake");
  chk_wake_no_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.resume |-> core_ctl.ext_clk_en && !sleeping && !stopped
    && periph_clk_en == $past(periph_en))
    else $error("wake did not restore clocks directly");
  chk_stop_resume_plain: assert property (@(posedge mclk) disable iff (!rst_n)
    stopped && wake_ext && !irq_prio_ok |=> core_ctl.resume && !core_ctl.take_irq)
    else $error("stop exit did not resume in sequence");
  chk_stop_take_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    stopped && wake_ext && irq_prio_ok |=> core_ctl.resume && core_ctl.take_irq)
    else $error("stop exit skipped interrupt processing");

  // Gate consistency: flags and gates flip on the same edge
  chk_modes_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
    !(sleeping && stopped))
    else $error("sleep and stop flags both set");
  chk_gate_matches_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ctl.core_clk_en == !(sleeping || stopped)
    && core_ctl.ext_clk_en == !stopped)
    else $error("clock gates out of step with mode flags");
endmodule

// file: verif/core_model.sv
// Core model: retires the pending instruction a cycle after a request
`timescale 1ns/1ps
module core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic want_sleep,
  input wire logic want_stop,
  output pwr_mgr_pkg::core_req_t core_req
);
  logic done_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) done_reg <= 1'h0;
    else done_reg <= want_sleep | want_stop;
  end
  // Stop is a control bit raised by software
  assign core_req = {want_sleep, want_stop, done_reg};
endmodule

// file: verif/sleep_stop_power_manager_test.sv
// Bench for the sleep and stop power manager
`timescale 1ns/1ps
module sleep_stop_power_manager_test;
  logic mclk = 1'h0, rst_n = 1'h0, want_sleep = 1'h0, want_stop = 1'h0;
  logic int_irq = 1'h0, prio_ok = 1'h0, sleeping, stopped;
  logic [3:0] ext_irq = 4'h0;
  logic [7:0] periph_en = 8'hff, periph_clk_en;
  pwr_mgr_pkg::core_req_t core_req;
  pwr_mgr_pkg::core_ctl_t core_ctl;
  int err_count = 0, compares = 0, n;
  always #5 mclk = ~mclk;
  core_model core_u (.mclk(mclk), .rst_n(rst_n), .want_sleep(want_sleep),
    .want_stop(want_stop), .core_req(core_req));
  sleep_stop_power_manager dut_u (.mclk(mclk), .rst_n(rst_n), .core_req(core_req),
    .periph_en(periph_en), .int_irq(int_irq), .ext_irq(ext_irq), .irq_prio_ok(prio_ok),
    .core_ctl(core_ctl), .periph_clk_en(periph_clk_en), .sleeping(sleeping),
    .stopped(stopped));
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Packs clock enables, wake pulses and mode flags into one byte
  function automatic logic [7:0] mode();
    return {2'h0, core_ctl, sleeping, stopped};
  endfunction
  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for the wake pulse; a hang ends the run as a failure
  task automatic wait_resume();
    for (n = 0; n < 8 && core_ctl.resume !== 1'h1; n++) tick();
    if (n == 8) begin
      $display("BAD resume expected 1 seen %b", core_ctl.resume);
      err_count++;
      stop_test();
    end
  endtask
  task automatic reset_check();
    repeat (20) tick();
    chk("rst mode", 8'h30, mode());
    chk("rst periph", 8'hff, periph_clk_en);
    rst_n = 1'h1;
  endtask
  task automatic sleep_wake(input logic prio, input logic by_ext);
    prio_ok = prio;
    want_sleep = 1'h1;
    tick();
    want_sleep = 1'h0;
    tick();
    chk("sleep", 8'h12, mode());
    chk("sleep periph", 8'hff, periph_clk_en);
    repeat (3) tick();
    chk("sleep hold", 8'h12, mode());
    if (by_ext) ext_irq = 4'h1;
    else int_irq = 1'h1;
    wait_resume();
    int_irq = 1'h0;
    ext_irq = 4'h0;
    chk("wake", prio ? 8'h3c : 8'h38, mode());
    // Off-chip lines pay two synchroniser edges before the wake edge
    chk("wake cycles", by_ext ? 8'h03 : 8'h01, 8'(n));
    tick();
    chk("run", 8'h30, mode());
  endtask
  task automatic periph_gate();
    periph_en = 8'h5a;
    repeat (2) tick();
    chk("periph", 8'h5a, periph_clk_en);
  endtask
  task automatic stop_wake(input logic prio);
    prio_ok = prio;
    want_stop = 1'h1;
    tick();
    want_stop = 1'h0;
    tick();
    chk("stop", 8'h01, mode());
    chk("stop periph", 8'h00, periph_clk_en);
    int_irq = 1'h1;
    repeat (2) tick();
    int_irq = 1'h0;
    chk("stop int", 8'h01, mode());
    ext_irq = 4'h8;
    // Wake goes through the two-flop synchroniser
    wait_resume();
    chk("stop wake", prio ? 8'h3c : 8'h38, mode());
    chk("stop periph on", 8'h5a, periph_clk_en);
    ext_irq = 4'h0;
    tick();
    chk("periph back", 8'h5a, periph_clk_en);
  endtask
  // Reset in mid-run, taken while the clocks are parked in stop
  task automatic reset_in_stop();
    want_stop = 1'h1;
    tick();
    want_stop = 1'h0;
    tick();
    chk("stop before rst", 8'h01, mode());
    rst_n = 1'h0;
    #1;
    chk("mid rst mode", 8'h30, mode());
    chk("mid rst periph", 8'hff, periph_clk_en);
    tick();
    rst_n = 1'h1;
    repeat (2) tick();
    chk("after rst mode", 8'h30, mode());
    chk("after rst periph", 8'h5a, periph_clk_en);
  endtask
  initial begin
    reset_check();
    sleep_wake(1'h1, 1'h0);
    sleep_wake(1'h0, 1'h1);
    periph_gate();
    stop_wake(1'h1);
    stop_wake(1'h0);
    reset_in_stop();
    stop_test();
  end
endmodule
